// [core/uus_divider.sv]
// Purpose: Unsigned restoring divider, one quotient bit per clock.
// Assumes: Divisor is never zero; start is ignored while busy.
// Notes:   Quotient is valid from the done pulse until the next start.
module uus_divider (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       start,
    input  wire logic [uus_pkg::DIV_W-1:0]  dividend,
    input  wire logic [uus_pkg::DVS_W-1:0]  divisor,
    output logic                            busy,
    output logic                            done,
    output logic [uus_pkg::DIV_W-1:0]       quotient
);
    import uus_pkg::*;

    logic [DVS_W-1:0] rem_q;
    logic [DVS_W-1:0] dvs_q;
    logic [DIV_W-1:0] quo_q;
    logic [6:0]       cnt_q;
    logic             busy_q;
    logic             done_q;
    wire  [DVS_W:0]   trial = {rem_q, quo_q[DIV_W-1]};
    wire  [DVS_W:0]   diff  = trial - {1'b0, dvs_q};
    wire              fits  = ~diff[DVS_W];

    always_ff @(posedge clk) begin
        if (rst) begin
            rem_q  <= '0;
            dvs_q  <= '0;
            quo_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                rem_q  <= '0;
                dvs_q  <= divisor;
                quo_q  <= dividend;
                cnt_q  <= DIV_CYCLES;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q  <= fits ? diff[DVS_W-1:0] : trial[DVS_W-1:0];
                quo_q  <= {quo_q[DIV_W-2:0], fits};
                cnt_q  <= cnt_q - 7'h01;
                if (cnt_q == 7'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign busy     = busy_q;
    assign done     = done_q;
    assign quotient = quo_q;

endmodule // uus_divider

// [core/uus_pkg.sv]
// Purpose: Shared constants and types of the user unit scaling stage.
// Assumes: One drive clock, synchronous active high reset.
// Notes:   Parameter addresses are the fieldbus parameter numbers.
package uus_pkg;

    // ==========================================================
    // Parameter addresses
    localparam logic [15:0] ADDR_POS_BOTTOM = 16'h060e;
    localparam logic [15:0] ADDR_POS_TOP    = 16'h0610;
    localparam logic [15:0] ADDR_VEL_BOTTOM = 16'h0642;
    localparam logic [15:0] ADDR_VEL_TOP    = 16'h0644;

    // ==========================================================
    // Factory values
    localparam logic [31:0] RST_POS_BOTTOM = 32'h0000_4000;
    localparam logic [31:0] RST_POS_TOP    = 32'h0000_0001;
    localparam logic [31:0] RST_VEL_BOTTOM = 32'h0000_0001;
    localparam logic [31:0] RST_VEL_TOP    = 32'h0000_0001;
    localparam logic [31:0] RATIO_MAX      = 32'h7fff_ffff;

    // ==========================================================
    // Internal position resolution and divider sizing
    localparam int          POS_RES_SHIFT  = 17;
    localparam int          DIV_W          = 96;
    localparam int          DVS_W          = 48;
    localparam logic [6:0]  DIV_CYCLES     = 7'h60;

    // ==========================================================
    // Conversion selectors
    localparam logic        KIND_POS       = 1'b0;
    localparam logic        KIND_VEL       = 1'b1;
    localparam logic        DIR_TO_INT     = 1'b0;
    localparam logic        DIR_TO_USER    = 1'b1;

    typedef enum logic [1:0] {
        UUS_IDLE,
        UUS_LOAD,
        UUS_DIV,
        UUS_DONE
    } uus_cnv_state_e;

endpackage : uus_pkg

// [core/uus_scaling.sv]
// Purpose: Position and velocity scaling between user units and internal units.
// Assumes: Power stage state comes from logic on the same clock.
// Notes:   Results are truncated toward zero and saturate at plus or minus RATIO_MAX.
//
// Overview of operation
// [R1] Convert user units to internal and back.
// [R2] Changed ratio reinterprets all user-unit values.
// [R3] Position ratio is revolutions over position units.
// [R4] Position ratio activates on numerator write only.
// [R5] Ratio writes only while power stage disabled.
// [R6] Tiny position ratio forbids moves beyond range.
// [R7] Position default: 1 revolution per 16384.
// [R8] Position fields signed 32-bit, 1 to max.
// [R9] Velocity ratio is rpm over velocity units.
// [R10] Velocity default: 1 rpm per unit.
// [R11] Velocity ratio activates on numerator write only.
// [R12] Velocity fields signed 32-bit, 1 to max.
// [R13] Each quantity uses its own user unit.
// [R14] Rejected writes leave everything unchanged.
module uus_scaling (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        power_stage_on,
    input  wire logic        par_wr,
    input  wire logic        par_rd,
    input  wire logic [15:0] par_addr,
    input  wire logic [31:0] par_wdata,
    output logic      [31:0] par_rdata,
    output logic             par_ack,
    output logic             par_err,
    input  wire logic        cnv_req,
    input  wire logic        cnv_kind,
    input  wire logic        cnv_dir,
    input  wire logic [31:0] cnv_in,
    output logic      [31:0] cnv_out,
    output logic             cnv_done,
    output logic             cnv_sat,
    output logic             cnv_busy,
    output logic      [31:0] pos_top_active,
    output logic      [31:0] pos_bottom_active,
    output logic      [31:0] vel_top_active,
    output logic      [31:0] vel_bottom_active,
    output logic             pos_range_lock
);
    import uus_pkg::*;

    // ==========================================================
    // Parameter access
    logic [31:0] pos_top_q, pos_bot_q, vel_top_q, vel_bot_q;
    logic [31:0] pos_top_act_q, pos_bot_act_q, vel_top_act_q, vel_bot_act_q;
    logic [31:0] rdata_q;
    logic        ack_q, err_q, lock_q;

    wire hit_pt  = (par_addr == ADDR_POS_TOP);
    wire hit_pb  = (par_addr == ADDR_POS_BOTTOM);
    wire hit_vt  = (par_addr == ADDR_VEL_TOP);
    wire hit_vb  = (par_addr == ADDR_VEL_BOTTOM);
    wire hit_any = hit_pt | hit_pb | hit_vt | hit_vb;
    wire in_range = !par_wdata[31] && (par_wdata != 32'h0);      // see [R8] see [R12]
    wire wr_ok   = par_wr && hit_any && in_range && !power_stage_on; // see [R5] see [R14]
    wire wr_bad  = par_wr && !wr_ok;
    wire [31:0] rd_mux = hit_pt ? pos_top_q : hit_pb ? pos_bot_q :
                         hit_vt ? vel_top_q : hit_vb ? vel_bot_q : 32'h0;
    // A ratio below one revolution per 2^17 units cannot address a whole step.
    wire lock_d = ({1'b0, pos_top_act_q[30:0], 17'h0} < {17'h0, pos_bot_act_q}); // see [R6]

    always_ff @(posedge clk) begin
        if (rst) begin
            pos_top_q     <= RST_POS_TOP;                          // see [R7]
            pos_bot_q     <= RST_POS_BOTTOM;
            pos_top_act_q <= RST_POS_TOP;
            pos_bot_act_q <= RST_POS_BOTTOM;
            vel_top_q     <= RST_VEL_TOP;                          // see [R10]
            vel_bot_q     <= RST_VEL_BOTTOM;
            vel_top_act_q <= RST_VEL_TOP;
            vel_bot_act_q <= RST_VEL_BOTTOM;
        end else if (wr_ok) begin
            // The bottom value waits in its stored copy until the top is written.
            if (hit_pb) pos_bot_q <= par_wdata;                    // see [R4]
            if (hit_vb) vel_bot_q <= par_wdata;                    // see [R11]
            if (hit_pt) begin
                pos_top_q     <= par_wdata;
                pos_top_act_q <= par_wdata;                        // see [R4] see [R3]
                pos_bot_act_q <= pos_bot_q;
            end
            if (hit_vt) begin
                vel_top_q     <= par_wdata;
                vel_top_act_q <= par_wdata;                        // see [R11] see [R9]
                vel_bot_act_q <= vel_bot_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            lock_q  <= 1'b0;
        end else begin
            ack_q   <= par_wr | par_rd;
            err_q   <= wr_bad | (par_rd && !hit_any);              // see [R14]
            rdata_q <= par_rd ? rd_mux : 32'h0;
            lock_q  <= lock_d;
        end
    end

    // ==========================================================
    // Conversion engine
    uus_cnv_state_e st_q;
    logic        sign_q, kind_q, dir_q, done_q, sat_q, busy_q;
    logic [31:0] mag_q, out_q;
    logic [DIV_W-1:0] quo;
    logic        div_busy, div_done;

    wire [31:0] in_mag  = cnv_in[31] ? (~cnv_in + 32'h1) : cnv_in;
    wire        is_pos  = (kind_q == KIND_POS);                    // see [R13]
    wire        to_int  = (dir_q == DIR_TO_INT);
    // Active factors only: pending bottom values never reach the math.
    wire [31:0] f_top   = is_pos ? pos_top_act_q : vel_top_act_q;  // see [R2]
    wire [31:0] f_bot   = is_pos ? pos_bot_act_q : vel_bot_act_q;
    wire [31:0] f_mul   = to_int ? f_top : f_bot;
    wire [63:0] prod    = {32'h0, mag_q} * {32'h0, f_mul};         // see [R1]
    wire [DIV_W-1:0] dvd = (is_pos && to_int) ? {15'h0, prod, 17'h0} : {32'h0, prod};
    wire [DVS_W-1:0] dvs = (is_pos && !to_int) ? {f_top[30:0], 17'h0} :
                           to_int ? {16'h0, f_bot} : {16'h0, f_top};
    wire        ovf     = (quo[DIV_W-1:31] != '0);
    wire [31:0] res_mag = ovf ? RATIO_MAX : quo[31:0];
    wire [31:0] res     = sign_q ? (~res_mag + 32'h1) : res_mag;

    uus_divider u_div (
        .clk      (clk),
        .rst      (rst),
        .start    (st_q == UUS_LOAD),
        .dividend (dvd),
        .divisor  (dvs),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (quo)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= UUS_IDLE;
            sign_q <= 1'b0;
            kind_q <= KIND_POS;
            dir_q  <= DIR_TO_INT;
            mag_q  <= 32'h0;
            out_q  <= 32'h0;
            done_q <= 1'b0;
            sat_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                UUS_IDLE: begin
                    if (cnv_req) begin
                        sign_q <= cnv_in[31];
                        kind_q <= cnv_kind;
                        dir_q  <= cnv_dir;
                        mag_q  <= in_mag;
                        st_q   <= UUS_LOAD;
                        busy_q <= 1'b1;
                    end
                end
                UUS_LOAD: st_q <= UUS_DIV;
                UUS_DIV: begin
                    if (div_done) begin
                        out_q  <= res;                             // see [R1]
                        sat_q  <= ovf;
                        done_q <= 1'b1;
                        st_q   <= UUS_DONE;
                    end
                end
                UUS_DONE: begin
                    busy_q <= 1'b0;
                    st_q   <= UUS_IDLE;
                end
                default: begin
                    busy_q <= 1'b0;
                    st_q   <= UUS_IDLE;
                end
            endcase
        end
    end

    assign par_rdata         = rdata_q;
    assign par_ack           = ack_q;
    assign par_err           = err_q;
    assign cnv_out           = out_q;
    assign cnv_done          = done_q;
    assign cnv_sat           = sat_q;
    assign cnv_busy          = busy_q;
    assign pos_top_active    = pos_top_act_q;
    assign pos_bottom_active = pos_bot_act_q;
    assign vel_top_active    = vel_top_act_q;
    assign vel_bottom_active = vel_bot_act_q;
    assign pos_range_lock    = lock_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cnv_start;
        (st_q == UUS_IDLE) && cnv_req;
    endsequence
    sequence s_cnv_finish;
        ##99 cnv_done;
    endsequence

    AST_CNV_LATENCY: assert property (s_cnv_start |-> s_cnv_finish) // see [R1]
        else $error("conversion did not finish in 99 cycles");
    AST_REJECT_POWER_ON: assert property (par_wr && power_stage_on |=> // see [R5]
        par_err && $stable(pos_top_q) && $stable(vel_bot_q) && $stable(pos_top_act_q))
        else $error("write accepted while power stage on");
    AST_REJECT_RANGE: assert property (par_wr && (par_wdata[31] || par_wdata == 32'h0) // see [R14]
        |=> par_err && $stable(pos_bot_q) && $stable(vel_top_act_q))
        else $error("out of range write accepted");
    AST_POS_BOTTOM_PENDING: assert property (wr_ok && hit_pb // see [R4]
        |=> pos_bot_q == $past(par_wdata) && $stable(pos_bot_act_q))
        else $error("position bottom write changed active ratio");
    AST_POS_TOP_ACTIVATES: assert property (wr_ok && hit_pt // see [R4]
        |=> pos_top_act_q == $past(par_wdata) && pos_bot_act_q == $past(pos_bot_q))
        else $error("position top write did not activate ratio");
    AST_VEL_BOTTOM_PENDING: assert property (wr_ok && hit_vb // see [R11]
        |=> vel_bot_q == $past(par_wdata) && $stable(vel_bot_act_q))
        else $error("velocity bottom write changed active ratio");
    AST_VEL_TOP_ACTIVATES: assert property (wr_ok && hit_vt // see [R11]
        |=> vel_top_act_q == $past(par_wdata) && vel_bot_act_q == $past(vel_bot_q))
        else $error("velocity top write did not activate ratio");
    AST_RANGE_LOCK: assert property ((pos_top_act_q == 32'h1) && // see [R6]
        (pos_bot_act_q > 32'h0002_0000) |=> pos_range_lock)
        else $error("range lock missing for small position ratio");
    AST_VALUES_LEGAL: assert property (pos_top_q != 32'h0 && !vel_bot_q[31] // see [R8]
        && vel_top_act_q != 32'h0 && !pos_bot_act_q[31])
        else $error("stored ratio outside legal range");
    AST_FACTORY: assert property ($fell(rst) |-> pos_bot_q == RST_POS_BOTTOM // see [R7]
        && pos_top_q == RST_POS_TOP && vel_top_q == RST_VEL_TOP && vel_bot_q == RST_VEL_BOTTOM)
        else $error("factory values not loaded");
    AST_DIV_RUNNING: assert property ((st_q == UUS_DIV) |-> (div_busy || div_done)) // see [R1]
        else $error("divider idle during conversion");
    AST_BUSY_WITH_DONE: assert property (cnv_done |-> cnv_busy) // see [R1]
        else $error("conversion result shown while not busy");

endmodule // uus_scaling

// [sim/testbench.sv]
// Purpose: Self-checking bench for the user unit scaling stage.
// Assumes: The master model drives the parameter port.
// Notes:   Expected answers are queued and compared when they appear.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import uus_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        power_stage_on, par_wr, par_rd, par_ack, par_err, pos_range_lock;
    logic [15:0] par_addr;
    logic [31:0] par_wdata, par_rdata, cnv_out, pta, pba, vta, vba;
    logic [31:0] cnv_in = 32'h0;
    logic        cnv_req = 1'b0, cnv_kind = 1'b0, cnv_dir = 1'b0, cnv_done, cnv_sat, cnv_busy;
    logic [32:0] par_q[$], cnv_q[$];
    int          miscompares = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    uus_master_model master (.clk(clk), .power_stage_on(power_stage_on), .par_wr(par_wr),
        .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata));
    uus_scaling dut (.clk(clk), .rst(rst), .power_stage_on(power_stage_on), .par_wr(par_wr),
        .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
        .par_ack(par_ack), .par_err(par_err), .cnv_req(cnv_req), .cnv_kind(cnv_kind),
        .cnv_dir(cnv_dir), .cnv_in(cnv_in), .cnv_out(cnv_out), .cnv_done(cnv_done),
        .cnv_sat(cnv_sat), .cnv_busy(cnv_busy), .pos_top_active(pta),
        .pos_bottom_active(pba), .vel_top_active(vta), .vel_bottom_active(vba),
        .pos_range_lock(pos_range_lock));
    // ==========================================================
    // Checking
    task automatic conclude();
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Sampling on the falling edge keeps clear of the registers' own updates.
    always @(negedge clk) begin
        if (par_ack === 1'b1)
            chk("parameter answer", par_q.size() ? par_q.pop_front() : 33'h1_dead_beef,
                {par_err, par_rdata});
        if (cnv_done === 1'b1)
            chk("conversion", cnv_q.size() ? cnv_q.pop_front() : 33'h1_dead_beef,
                {cnv_sat, cnv_out});
    end
    function automatic logic [32:0] model(input logic k, d, input logic [31:0] v, t, b);
        logic [31:0]  m;
        logic [127:0] num;
        logic [127:0] den;
        logic [127:0] q;
        m   = v[31] ? -v : v;
        num = 128'(m) * 128'(d ? b : t) * ((!k && !d) ? 128'h2_0000 : 128'h1);
        den = 128'(d ? t : b) * ((!k && d) ? 128'h2_0000 : 128'h1);
        q   = num / den;
        if (q > 128'h7fff_ffff)
            return {1'b1, v[31] ? -RATIO_MAX : RATIO_MAX};
        return {1'b0, v[31] ? -q[31:0] : q[31:0]};
    endfunction
    // ==========================================================
    // Drivers
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        par_q.push_back({e, 32'h0});
        master.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic e);
        par_q.push_back({e, x});
        master.access(1'b0, a, 32'h0);
    endtask
    task automatic act(input logic [31:0] t, b, u, w);
        repeat (2) @(posedge clk);
        #1;
        chk("pos_top_active", {1'b0, t}, {1'b0, pta});
        chk("pos_bottom_active", {1'b0, b}, {1'b0, pba});
        chk("vel_top_active", {1'b0, u}, {1'b0, vta});
        chk("vel_bottom_active", {1'b0, w}, {1'b0, vba});
    endtask
    task automatic lock(input logic e);
        repeat (3) @(posedge clk);
        #1;
        chk("pos_range_lock", {32'h0, e}, {32'h0, pos_range_lock});
    endtask
    task automatic cnv(input logic k, d, input logic [31:0] v, t, b);
        int n;
        n = 0;
        cnv_q.push_back(model(k, d, v, t, b));
        @(posedge clk);
        #1;
        cnv_kind = k;
        cnv_dir  = d;
        cnv_in   = v;
        cnv_req  = 1'b1;
        @(posedge clk);
        #1;
        cnv_req  = 1'b0;
        cnv_in   = ~v;
        while (cnv_busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 200) begin
            miscompares++;
            conclude();
        end
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        logic [31:0] v;
        void'($urandom(32'h8c3dc9f1));
        v = $urandom_range(32'h4e20, 32'h1);
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(ADDR_POS_BOTTOM, 32'h4000, 1'b0);
        rd(ADDR_POS_TOP, 32'h1, 1'b0);
        rd(ADDR_VEL_BOTTOM, 32'h1, 1'b0);
        rd(ADDR_VEL_TOP, 32'h1, 1'b0);
        act(32'h1, 32'h4000, 32'h1, 32'h1);
        wr(ADDR_POS_BOTTOM, 32'he10, 1'b0);
        act(32'h1, 32'h4000, 32'h1, 32'h1);
        rd(ADDR_POS_BOTTOM, 32'he10, 1'b0);
        cnv(KIND_POS, DIR_TO_INT, v, 32'h1, 32'h4000);
        wr(ADDR_POS_TOP, 32'h1, 1'b0);
        act(32'h1, 32'he10, 32'h1, 32'h1);
        cnv(KIND_POS, DIR_TO_INT, v, 32'h1, 32'he10);
        cnv(KIND_POS, DIR_TO_USER, -v, 32'h1, 32'he10);
        wr(ADDR_VEL_BOTTOM, 32'h3, 1'b0);
        cnv(KIND_VEL, DIR_TO_INT, v, 32'h1, 32'h1);
        wr(ADDR_VEL_TOP, 32'h2, 1'b0);
        act(32'h1, 32'he10, 32'h2, 32'h3);
        cnv(KIND_VEL, DIR_TO_INT, -v, 32'h2, 32'h3);
        cnv(KIND_VEL, DIR_TO_USER, v, 32'h2, 32'h3);
        master.pwr(1'b1);
        wr(ADDR_VEL_TOP, 32'h5, 1'b1);
        wr(ADDR_POS_BOTTOM, 32'h5, 1'b1);
        master.pwr(1'b0);
        wr(ADDR_VEL_TOP, 32'h0, 1'b1);
        wr(ADDR_POS_TOP, 32'h8000_0000, 1'b1);
        wr(16'h0612, 32'h1, 1'b1);
        rd(16'h0612, 32'h0, 1'b1);
        rd(ADDR_VEL_TOP, 32'h2, 1'b0);
        rd(ADDR_POS_BOTTOM, 32'he10, 1'b0);
        act(32'h1, 32'he10, 32'h2, 32'h3);
        wr(ADDR_POS_BOTTOM, RATIO_MAX, 1'b0);
        wr(ADDR_POS_TOP, 32'h1, 1'b0);
        lock(1'b1);
        wr(ADDR_POS_BOTTOM, 32'h2_0000, 1'b0);
        wr(ADDR_POS_TOP, 32'h1, 1'b0);
        lock(1'b0);
        wr(ADDR_POS_BOTTOM, 32'h1, 1'b0);
        wr(ADDR_POS_TOP, RATIO_MAX, 1'b0);
        cnv(KIND_POS, DIR_TO_INT, v, RATIO_MAX, 32'h1);
        repeat (3) @(posedge clk);
        chk("queues empty", 33'h0, 33'(par_q.size() + cnv_q.size()));
        conclude();
    end
endmodule // testbench

// [sim/uus_master_model.sv]
// Purpose: Fieldbus master model for the scaling parameters.
// Assumes: One-cycle strobes; the block answers one cycle later.
// Notes:   Released address and data lines show the inverse of the last value; strobes return to zero.
module uus_master_model (
    input  wire logic        clk,
    output logic             power_stage_on,
    output logic             par_wr,
    output logic             par_rd,
    output logic      [15:0] par_addr,
    output logic      [31:0] par_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        power_stage_on = 1'b0;
        par_wr         = 1'b0;
        par_rd         = 1'b0;
        par_addr       = 16'h0;
        par_wdata      = 32'h0;
    end
    // ==========================================================
    // Requests
    // Ratios are written with the power stage off unless a refusal is wanted.
    task automatic pwr(input logic on);
        @(posedge clk);
        #1;
        power_stage_on = on;
    endtask
    task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        par_wr    = w;
        par_rd    = ~w;
        par_addr  = a;
        par_wdata = d;
        @(posedge clk);
        #1;
        par_wr    = 1'b0;
        par_rd    = 1'b0;
        par_addr  = ~a;
        par_wdata = ~d;
    endtask
endmodule // uus_master_model
